/* File: src/fpe_cfg.svh */
// constants of the flash program and erase command sequencer
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH

// -----------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------
`define FPE_OP_WREN        8'h06
`define FPE_OP_PROG        8'h02
`define FPE_OP_QPROG       8'h32
`define FPE_OP_ERASE_4K    8'h20
`define FPE_OP_ERASE_32K   8'h52
`define FPE_OP_ERASE_64K   8'hD8
`define FPE_OP_CHIP_A      8'h60
`define FPE_OP_CHIP_B      8'hC7

// -----------------------------------------------------------------
// frame layout: byte counts including the opcode, then bits moved per serial clock
// -----------------------------------------------------------------
`define FPE_BYTES_OPCODE   3'h1
`define FPE_BYTES_ADDR     3'h4
`define FPE_BYTES_DATA     3'h5
`define FPE_STEP_SINGLE    3'h1
`define FPE_STEP_QUAD      3'h4

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define FPE_ERASE_4K_BITS  12
`define FPE_ERASE_32K_BITS 15
`define FPE_ERASE_64K_BITS 16
`define FPE_PROT_MSB       22
`define FPE_PROT_LSB       16
`define FPE_WEL_RESET      1'b0
`define FPE_WIP_RESET      1'b0

// -----------------------------------------------------------------
// timing: clock rate and self-timed cycle lengths
// -----------------------------------------------------------------
`define FPE_CLK_MHZ        100
`define FPE_T_PP_US        1000
`define FPE_T_BP_US        100
`define FPE_T_BE_MS        100
`define FPE_T_CE_MS        1000

`endif

/* File: src/fpe_pkg.sv */
// types shared by the flash program and erase command sequencer
package fpe_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SHIFT = 2'h1,
		ST_WRITE = 2'h2,
		ST_WAIT  = 2'h3
	} fpe_state_e;

	// erase region kinds presented to the array
	typedef enum logic [1:0] {
		ER_4K   = 2'h0,
		ER_32K  = 2'h1,
		ER_64K  = 2'h2,
		ER_CHIP = 2'h3
	} fpe_erase_e;

endpackage

/* File: src/fpe_page_buf.sv */
// page buffer: one byte and one written mark per page location
module fpe_page_buf #(
	parameter int DEPTH = 256,
	parameter int WIDTH = 8,
	parameter int IDX_W = 8
)(
	// clock and reset
	input  wire logic             CLK,
	input  wire logic             RESET_N,
	// fill side
	input  wire logic             clr,
	input  wire logic             wr_en,
	input  wire logic [IDX_W-1:0] wr_idx,
	input  wire logic [WIDTH-1:0] wr_data,
	// drain side
	input  wire logic [IDX_W-1:0] rd_idx,
	output logic      [WIDTH-1:0] rd_data,
	output logic                  rd_valid
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [DEPTH-1:0] valid_reg;

	// data storage needs no reset: a location's byte is only programmed when marked
	always_ff @(posedge CLK) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// written marks, cleared all at once at the start of a frame
	genvar i;
	for (i = 0; i < DEPTH; i++) begin : g_mark
		always_ff @(posedge CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				valid_reg[i] <= 1'b0;
			end else if (clr) begin
				valid_reg[i] <= 1'b0;
			end else if (wr_en && (wr_idx == IDX_W'(i))) begin
				valid_reg[i] <= 1'b1;
			end
		end
	end

	assign rd_data  = mem[rd_idx];
	assign rd_valid = valid_reg[rd_idx];

endmodule

/* File: src/fpe_top.sv */
// flash program and erase command sequencer, device side
// What this block does
// - program opcode, three address bytes, then data bytes fill a page buffer
// - program runs only when the write latch flag was set before
// - data past the page end wraps to the start of the same page
// - more than a page of data keeps only the latest 256 bytes
// - on deselect buffered bytes are programmed; untouched locations stay erased
// - full address, one whole data byte, byte-aligned end, else nothing programmed
// - protected target: program not executed, back to idle on deselect
// - aborted or protected program clears the write latch flag
// - busy shown during program; write latch flag cleared before the end
// - quad program uses four lanes, accepted only with quad lane enable set
// - quad program must end after the last bit of a whole byte
// - quad cycle starts at deselect; in-progress flag high until done
// - quad program to a protected page is refused
// - three block erase opcodes select 4K, 32K or 64K regions
// - block erase takes three address bytes, ignores the rest, starts on deselect
// - low address bits 11:0, 14:0 or 15:0 ignored per erase size
// - short address, misaligned end or protection aborts erase, clears the latch
// - erase runs only when the write latch flag was set before
// - both chip erase opcodes alike, no address, whole array erased
// - misaligned end or protection: no chip erase, latch cleared
// - busy shown during erase; write latch flag cleared before the end
// - complete byte-aligned write-enable frame sets the write latch flag
`include "fpe_cfg.svh"

module fpe_top
	import fpe_pkg::*;
#(
	parameter int T_PP_US = `FPE_T_PP_US,
	parameter int T_BP_US = `FPE_T_BP_US,
	parameter int T_BE_MS = `FPE_T_BE_MS,
	parameter int T_CE_MS = `FPE_T_CE_MS
)(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	// serial link pins
	input  wire logic        CS_N,
	input  wire logic        SCK,
	input  wire logic [3:0]  IO,
	// configuration
	input  wire logic        QUAD_LANE_ENABLE_FLAG,
	input  wire logic [4:0]  BLOCK_PROTECT_BITS,
	// status
	output logic             WRITE_LATCH_FLAG,
	output logic             WRITE_IN_PROGRESS_FLAG,
	// array operations
	output logic             ARRAY_PROG,
	output logic             ARRAY_ERASE,
	output logic [1:0]       ARRAY_ERASE_KIND,
	output logic [23:0]      ARRAY_ADDR,
	output logic [7:0]       ARRAY_DATA
);

	// -----------------------------------------------------------------
	// self-timed cycle lengths in clock cycles
	// -----------------------------------------------------------------
	localparam logic [31:0] PP_CYC = 32'(T_PP_US * `FPE_CLK_MHZ);
	localparam logic [31:0] BP_CYC = 32'(T_BP_US * `FPE_CLK_MHZ);
	localparam logic [31:0] BE_CYC = 32'(T_BE_MS * 1000 * `FPE_CLK_MHZ);
	localparam logic [31:0] CE_CYC = 32'(T_CE_MS * 1000 * `FPE_CLK_MHZ);

	// -----------------------------------------------------------------
	// pin synchronisers and edge detection
	// -----------------------------------------------------------------
	logic [5:0] pin_meta_reg;
	logic [5:0] pin_sync_reg;
	logic [1:0] pin_prev_reg;

	// pins are asynchronous to CLK, so two flops before any use
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pin_meta_reg <= 6'h20;
			pin_sync_reg <= 6'h20;
			pin_prev_reg <= 2'h2;
		end else begin
			pin_meta_reg <= {CS_N, SCK, IO};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg[5:4];
		end
	end

	wire       cs_n_s   = pin_sync_reg[5];
	wire [3:0] io_s     = pin_sync_reg[3:0];
	wire       cs_fall  = pin_prev_reg[1] && !cs_n_s;
	wire       cs_rise  = !pin_prev_reg[1] && cs_n_s;
	wire       sck_rise = !pin_prev_reg[0] && pin_sync_reg[4] && !cs_n_s;

	// -----------------------------------------------------------------
	// state and frame registers
	// -----------------------------------------------------------------
	fpe_state_e  state_reg, state_next;
	logic [7:0]  sh_reg, op_reg;
	logic [2:0]  bit_reg, byte_reg;
	logic [23:0] addr_reg;
	logic [7:0]  didx_reg;
	logic        many_reg;
	logic [7:0]  walk_reg;
	logic [31:0] tmr_reg;
	logic        wel_reg, wip_reg;
	logic        prog_reg, erase_reg;
	logic [1:0]  kind_reg;
	logic [23:0] aout_reg;
	logic [7:0]  dout_reg;

	// -----------------------------------------------------------------
	// shifter decode
	// -----------------------------------------------------------------
	wire       in_shift   = (state_reg == ST_SHIFT);
	wire       is_qprog   = (op_reg == `FPE_OP_QPROG) && QUAD_LANE_ENABLE_FLAG;
	wire       is_prog    = (op_reg == `FPE_OP_PROG) || is_qprog;
	wire       in_data    = (byte_reg >= `FPE_BYTES_ADDR);
	wire       quad_phase = is_qprog && in_data;
	wire [2:0] step       = quad_phase ? `FPE_STEP_QUAD : `FPE_STEP_SINGLE;
	wire [2:0] bit_next   = bit_reg + step;
	// msb first; quad data moves the high nibble in first
	wire [7:0] sh_next    = quad_phase ? {sh_reg[3:0], io_s} : {sh_reg[6:0], io_s[0]};
	wire       shift_en   = in_shift && sck_rise;
	wire       byte_done  = shift_en && (bit_next == 3'h0);
	wire       first_byte = byte_done && (byte_reg == 3'h0);
	wire       addr_byte  = byte_done && (byte_reg != 3'h0) && !in_data;
	// data index wraps inside the page; later bytes overwrite older ones
	wire       data_wr    = byte_done && in_data && is_prog;
	wire [7:0] data_idx   = addr_reg[7:0] + didx_reg;

	// -----------------------------------------------------------------
	// command decision on deselect
	// -----------------------------------------------------------------
	wire aligned   = (bit_reg == 3'h0);
	wire is_b4     = (op_reg == `FPE_OP_ERASE_4K);
	wire is_b32    = (op_reg == `FPE_OP_ERASE_32K);
	wire is_b64    = (op_reg == `FPE_OP_ERASE_64K);
	wire is_blk    = is_b4 || is_b32 || is_b64;
	wire is_chip   = (op_reg == `FPE_OP_CHIP_A) || (op_reg == `FPE_OP_CHIP_B);
	wire has_op    = (byte_reg >= `FPE_BYTES_OPCODE);
	wire pe_cmd    = has_op && (is_prog || is_blk || is_chip);
	wire we_ok     = has_op && aligned && (op_reg == `FPE_OP_WREN);

	// protection covers the top 2^(bp-1) 64K blocks; eight or more covers all
	wire [2:0] bp_m1  = 3'(BLOCK_PROTECT_BITS - 5'h01);
	wire [6:0] blk_hi = ~addr_reg[`FPE_PROT_MSB:`FPE_PROT_LSB];
	wire bp_any       = (BLOCK_PROTECT_BITS != 5'h00);
	wire prot_hit     = bp_any && ((BLOCK_PROTECT_BITS >= 5'h08) || ((blk_hi >> bp_m1) == 7'h00));
	wire hit          = is_chip ? bp_any : prot_hit;

	// frame shape: program needs a data byte, block erase an address
	wire form_ok = aligned && (is_prog ? (byte_reg >= `FPE_BYTES_DATA) :
		is_blk ? (byte_reg >= `FPE_BYTES_ADDR) : has_op);
	wire go      = in_shift && cs_rise && pe_cmd && wel_reg && form_ok && !hit;
	wire fail    = in_shift && cs_rise && pe_cmd && wel_reg && !go;

	// erase base: low bits dropped per region size
	wire [23:0] base_4k  = {addr_reg[23:`FPE_ERASE_4K_BITS], 12'h000};
	wire [23:0] base_32k = {addr_reg[23:`FPE_ERASE_32K_BITS], 15'h0000};
	wire [23:0] base_64k = {addr_reg[23:`FPE_ERASE_64K_BITS], 16'h0000};
	wire [23:0] base     = is_b4 ? base_4k : is_b32 ? base_32k : is_b64 ? base_64k : 24'h000000;
	wire [1:0]  kind     = is_b4 ? ER_4K : is_b32 ? ER_32K : is_b64 ? ER_64K : ER_CHIP;
	wire [31:0] t_erase  = is_chip ? CE_CYC : BE_CYC;

	// -----------------------------------------------------------------
	// page buffer and its drain
	// -----------------------------------------------------------------
	wire [7:0] rd_data;
	wire       rd_valid;
	wire       walk_last = (walk_reg == 8'hFF);
	wire       tmr_done  = (tmr_reg == 32'h00000000);

	fpe_page_buf #(
		.DEPTH (256),
		.WIDTH (8),
		.IDX_W (8)
	) u_buf (
		.CLK      (CLK),
		.RESET_N  (RESET_N),
		.clr      (cs_fall && (state_reg == ST_IDLE)),
		.wr_en    (data_wr),
		.wr_idx   (data_idx),
		.wr_data  (sh_next),
		.rd_idx   (walk_reg),
		.rd_data  (rd_data),
		.rd_valid (rd_valid)
	);

	// -----------------------------------------------------------------
	// state machine; link activity is ignored while busy
	// -----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:  if (cs_fall) state_next = ST_SHIFT;
			ST_SHIFT: begin
				if (go && is_prog) begin
					state_next = ST_WRITE;
				end else if (go) begin
					state_next = ST_WAIT;
				end else if (cs_rise) begin
					state_next = ST_IDLE;
				end
			end
			ST_WRITE: if (walk_last) state_next = ST_WAIT;
			ST_WAIT:  if (tmr_done) state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// frame shifter: opcode, address high byte first, data index
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sh_reg   <= 8'h00;
			op_reg   <= 8'h00;
			bit_reg  <= 3'h0;
			byte_reg <= 3'h0;
			addr_reg <= 24'h000000;
			didx_reg <= 8'h00;
			many_reg <= 1'b0;
		end else if (state_reg == ST_IDLE) begin
			bit_reg  <= 3'h0;
			byte_reg <= 3'h0;
			op_reg   <= 8'h00;
			didx_reg <= 8'h00;
			many_reg <= 1'b0;
		end else if (shift_en) begin
			sh_reg  <= sh_next;
			bit_reg <= bit_next;
			if (first_byte) op_reg <= sh_next;
			if (addr_byte) addr_reg <= {addr_reg[15:0], sh_next};
			if (byte_done && byte_reg != `FPE_BYTES_DATA) byte_reg <= byte_reg + 3'h1;
			if (data_wr) didx_reg <= didx_reg + 8'h01;
			if (data_wr && byte_reg == `FPE_BYTES_DATA) many_reg <= 1'b1;
		end
	end

	// next values: walk over all 256 locations, timer (single byte uses the shorter figure),
	// latch set by write enable and dropped on abort or cycle start, busy until timer ends
	wire [7:0]  walk_next = (state_reg == ST_WRITE) ? walk_reg + 8'h01 : 8'h00;
	wire [31:0] tmr_next  = (go && !is_prog) ? t_erase - 32'h00000001 :
		(state_reg == ST_WRITE && walk_last) ? (many_reg ? PP_CYC : BP_CYC) - 32'h00000001 :
		(state_reg == ST_WAIT && !tmr_done) ? tmr_reg - 32'h00000001 : tmr_reg;
	wire        wel_next  = (in_shift && cs_rise && we_ok) ? 1'b1 :
		(go || fail) ? 1'b0 : wel_reg;
	wire        wip_next  = go ? 1'b1 :
		(state_reg == ST_WAIT && tmr_done) ? 1'b0 : wip_reg;

	// one short process holds walk, timer and both flags; unmarked locations stay erased
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			walk_reg <= 8'h00;
			tmr_reg  <= 32'h00000000;
			wel_reg  <= `FPE_WEL_RESET;
			wip_reg  <= `FPE_WIP_RESET;
		end else begin
			walk_reg <= walk_next;
			tmr_reg  <= tmr_next;
			wel_reg  <= wel_next;
			wip_reg  <= wip_next;
		end
	end

	// array command outputs
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			prog_reg  <= 1'b0;
			erase_reg <= 1'b0;
			kind_reg  <= ER_4K;
			aout_reg  <= 24'h000000;
			dout_reg  <= 8'hFF;
		end else begin
			prog_reg  <= (state_reg == ST_WRITE) && rd_valid;
			erase_reg <= go && !is_prog;
			if (state_reg == ST_WRITE) begin
				aout_reg <= {addr_reg[23:8], walk_reg};
				dout_reg <= rd_data;
			end else if (go && !is_prog) begin
				aout_reg <= base;
				kind_reg <= kind;
			end
		end
	end

	assign WRITE_LATCH_FLAG       = wel_reg;
	assign WRITE_IN_PROGRESS_FLAG = wip_reg;
	assign ARRAY_PROG             = prog_reg;
	assign ARRAY_ERASE            = erase_reg;
	assign ARRAY_ERASE_KIND       = kind_reg;
	assign ARRAY_ADDR             = aout_reg;
	assign ARRAY_DATA             = dout_reg;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	chk_we_sets_latch: assert property (
		@(posedge CLK) disable iff (!RESET_N) in_shift && cs_rise && we_ok |=> wel_reg)
		else $error("write enable frame did not set the latch");
	chk_no_latch_no_run: assert property (
		@(posedge CLK) disable iff (!RESET_N) in_shift && cs_rise && !wel_reg |=> !wip_reg && state_reg == ST_IDLE)
		else $error("command ran without the write latch");
	chk_abort_clears: assert property (
		@(posedge CLK) disable iff (!RESET_N) fail |=> !wel_reg && !wip_reg && state_reg == ST_IDLE)
		else $error("aborted command left latch set or started");
	chk_busy_no_latch: assert property (
		@(posedge CLK) disable iff (!RESET_N) wip_reg |-> !wel_reg)
		else $error("write latch still set during a cycle");
	chk_start_busy: assert property (
		@(posedge CLK) disable iff (!RESET_N) go |=> wip_reg throughout (state_reg != ST_IDLE)[*2])
		else $error("cycle start did not raise in-progress");
	chk_quad_needs_qe: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		in_shift && cs_rise && op_reg == `FPE_OP_QPROG && !QUAD_LANE_ENABLE_FLAG |=> !wip_reg)
		else $error("quad program ran with lanes disabled");
	chk_protect_block: assert property (
		@(posedge CLK) disable iff (!RESET_N) in_shift && cs_rise && pe_cmd && hit |=> !wip_reg)
		else $error("protected target was written");
	chk_short_frame: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		in_shift && cs_rise && is_prog && (byte_reg < `FPE_BYTES_DATA || !aligned) |=> !wip_reg)
		else $error("short program frame was executed");
	chk_prog_in_page: assert property (
		@(posedge CLK) disable iff (!RESET_N) ARRAY_PROG |-> ARRAY_ADDR[23:8] == addr_reg[23:8])
		else $error("program left its page");
	chk_erase_align: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		ARRAY_ERASE |-> (ARRAY_ERASE_KIND != ER_4K || ARRAY_ADDR[11:0] == 12'h000)
		&& (ARRAY_ERASE_KIND != ER_32K || ARRAY_ADDR[14:0] == 15'h0000)
		&& (ARRAY_ERASE_KIND != ER_64K || ARRAY_ADDR[15:0] == 16'h0000))
		else $error("erase base not region aligned");

endmodule

/* File: dv/fpe_host_model.sv */
// host serial controller model driving the flash link pins
module fpe_host_model (
	// clock
	input  wire logic  CLK,
	// link pins
	output logic       CS_N,
	output logic       SCK,
	output logic [3:0] IO
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] tx_q[$]; // bytes of the next frame

	// idle link: deselected, serial clock parked low
	initial begin
		CS_N = 1'b1;
		SCK  = 1'b0;
		IO   = 4'hF;
	end

	// wait a number of system clock edges
	task automatic edges(input int n);
		repeat (n) @(posedge CLK);
	endtask

	// one serial clock: data set while low, held through the rise
	task automatic clk_out(input logic [3:0] v);
		IO  <= v;
		SCK <= 1'b0;
		edges(4);
		SCK <= 1'b1;
		edges(4);
	endtask

	// send queued bytes; extra clocks past the last byte break alignment on purpose
	task automatic send(input bit quad, input int extra);
		int i;
		int k;
		@(posedge CLK);
		CS_N <= 1'b0;
		edges(4);
		for (i = 0; i < tx_q.size(); i++) begin
			if (quad && i >= 4) begin
				clk_out(tx_q[i][7:4]);
				clk_out(tx_q[i][3:0]);
			end else begin
				for (k = 7; k >= 0; k--) begin
					clk_out({3'h0, tx_q[i][k]});
				end
			end
		end
		for (k = 0; k < extra; k++) begin
			clk_out(4'h5);
		end
		SCK <= 1'b0;
		edges(4);
		CS_N <= 1'b1;
		IO   <= ~IO;  // released lines must not keep the last value
		edges(6);
		tx_q.delete();
	endtask
endmodule

/* File: dv/flash_program_erase_commands_tb.sv */
// self-checking bench of the flash program and erase command sequencer
module flash_program_erase_commands_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// -----------------------------------------------------------------
	// signals and model state
	// -----------------------------------------------------------------
	logic        CLK     = 1'b0;
	logic        RESET_N = 1'b0;
	logic        qe      = 1'b1;
	logic [4:0]  bp      = 5'h00;
	logic        cs_n;
	logic        sck;
	logic [3:0]  io;
	logic        wel_o;
	logic        write_in_progress_flag;
	logic        prog;
	logic        erase;
	logic [1:0]  kind;
	logic [23:0] addr;
	logic [7:0]  data;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          busy_cyc  = 0;     // clock edges seen with the busy flag high
	int          write_latch_flag       = 0;     // model of the write latch flag
	logic [31:0] lfsr      = 32'h6026;
	logic [31:0] prog_q[$];         // seen program strobes {addr, data}
	logic [25:0] ers_q[$];          // seen erase strobes {kind, addr}
	logic [7:0]  codes[5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};

	always #5 CLK = ~CLK;

	// long cycles shortened; page time kept apart from single-byte time (200 vs 100 cycles)
	fpe_top #(.T_PP_US(2), .T_BP_US(1), .T_BE_MS(1), .T_CE_MS(1)) i_fpe_top (
		.CLK(CLK), .RESET_N(RESET_N), .CS_N(cs_n), .SCK(sck), .IO(io),
		.QUAD_LANE_ENABLE_FLAG(qe), .BLOCK_PROTECT_BITS(bp),
		.WRITE_LATCH_FLAG(wel_o), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag),
		.ARRAY_PROG(prog), .ARRAY_ERASE(erase), .ARRAY_ERASE_KIND(kind),
		.ARRAY_ADDR(addr), .ARRAY_DATA(data));

	fpe_host_model i_fpe_host_model (.CLK(CLK), .CS_N(cs_n), .SCK(sck), .IO(io));

	// collect array strobes as they are seen
	always @(posedge CLK) begin
		if (prog === 1'b1) prog_q.push_back({addr, data});
		if (erase === 1'b1) ers_q.push_back({kind, addr});
		if (write_in_progress_flag === 1'b1) busy_cyc++;
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	// bounded poll of the busy flag, sampled after the edge settles
	task automatic wait_wip(input logic v, input int n);
		int i;
		for (i = 0; i < n && write_in_progress_flag !== v; i++) begin
			@(posedge CLK);
			#1;
		end
		if (write_in_progress_flag !== v) begin
			error_cnt++;
			$display("FAIL %0t busy flag wait timed out", $time);
			conclude();
		end
	endtask

	task automatic reset_dut();
		RESET_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RESET_N <= 1'b1;
		repeat (4) @(posedge CLK);
		write_latch_flag = 0;
	endtask

	// top 2^(bp-1) of the 64K blocks are protected, all from 8 up
	function automatic bit prot(input int a);
		if (bp == 0) return 0;
		if (bp >= 8) return 1;
		return ((a >> 16) & 32'h7F) >= 128 - (1 << (bp - 1));
	endfunction

	// one frame plus the expected outcome worked out from the command rules
	task automatic op(input logic [7:0] opc, input int a, input int n, input int extra,
		input int nab);
		int          i;
		int          k;
		int          m;
		int          b0;
		bit          is_p;
		bit          is_b;
		bit          run;
		logic [7:0]  d;
		logic [7:0]  mem[256];
		bit          mark[256];
		logic [31:0] exp_q[$];
		is_p = (opc == 8'h02) || (opc == 8'h32);
		is_b = (opc == 8'h20) || (opc == 8'h52) || (opc == 8'hD8);
		i_fpe_host_model.tx_q.push_back(opc);
		for (i = 2; i >= 3 - nab; i--) i_fpe_host_model.tx_q.push_back(8'(a >> (8 * i)));
		for (i = 0; i < n; i++) begin
			d = 8'(rnd());
			i_fpe_host_model.tx_q.push_back(d);
			mem[(a + i) & 255] = d;
			mark[(a + i) & 255] = 1'b1;
		end
		prog_q.delete();
		ers_q.delete();
		b0 = busy_cyc;
		i_fpe_host_model.send(opc == 8'h32, extra);
		run = 0;
		if (opc == 8'h06) begin
			if (extra == 0) write_latch_flag = 1;
		end else if ((opc != 8'h32 || qe) && write_latch_flag != 0) begin
			run = extra == 0 && (is_p ? nab == 3 && n > 0 : !is_b || nab == 3);
			run = run && !((is_p || is_b) ? prot(a) : bp != 0);
			write_latch_flag = 0;
		end
		if (!run) begin
			repeat (12) @(posedge CLK);
			check(prog_q.size() + ers_q.size(), 0);
		end else if (is_p) begin
			wait_wip(1'b1, 12);
			check(wel_o, 0);
			wait_wip(1'b0, 1200);
			// busy spans the 256-location walk plus page or single-byte program time
			check(busy_cyc - b0, 256 + (n > 1 ? 200 : 100));
			for (i = 0; i < 256; i++) if (mark[i]) exp_q.push_back({a[23:8], i[7:0], mem[i]});
			check(prog_q.size(), exp_q.size());
			for (i = 0; i < exp_q.size() && i < prog_q.size(); i++) check(prog_q[i], exp_q[i]);
		end else begin
			wait_wip(1'b1, 12);
			check(wel_o, 0);
			repeat (2) @(posedge CLK);
			check(ers_q.size(), 1);
			k = is_b ? (opc == 8'h20 ? 0 : opc == 8'h52 ? 1 : 2) : 3;
			m = k == 0 ? 32'hFFF : k == 1 ? 32'h7FFF : 32'hFFFF;
			if (ers_q.size() == 1) check(ers_q[0][25:24], k);
			if (ers_q.size() == 1 && k < 3) check(ers_q[0][23:0], a & ~m & 32'hFFFFFF);
			reset_dut();              // cuts the long erase short
		end
		check(wel_o, write_latch_flag);
	endtask

	task automatic wren();
		op(8'h06, 0, 0, 0, 0);
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	initial begin
		int j;
		reset_dut();
		op(8'h02, 32'h0000FE, 3, 0, 3);
		wren();
		op(8'h02, 32'h0000FE, 3, 0, 3);
		wren();
		op(8'h02, 32'h123480, 258, 0, 3);
		wren();
		op(8'h02, 32'h001000, 0, 0, 3);
		wren();
		op(8'h02, 32'h001000, 2, 3, 3);
		wren();
		op(8'h02, 32'h001000, 0, 0, 2);
		bp <= 5'h01;
		wren();
		op(8'h02, 32'h7F0010, 2, 0, 3);
		wren();
		op(8'h32, 32'h7F0000, 2, 0, 3);
		bp <= 5'h00;
		wren();
		op(8'h32, rnd() & 32'h3FFFFF, 5, 0, 3);
		wren();
		op(8'h32, 32'h002000, 2, 1, 3);
		qe <= 1'b0;
		wren();
		op(8'h32, 32'h002000, 2, 0, 3);
		qe <= 1'b1;
		op(8'h02, 32'h0030FF, 1, 0, 3);
		for (j = 0; j < 5; j++) begin
			wren();
			op(codes[j], rnd() & 32'hFFFFFF, 2, 0, j < 3 ? 3 : 0);
		end
		wren();
		op(8'h20, 32'h004000, 0, 0, 2);
		wren();
		op(8'hC7, 0, 0, 3, 0);
		bp <= 5'h01;
		wren();
		op(8'hD8, 32'h7F1234, 0, 0, 3);
		wren();
		op(8'h60, 0, 0, 0, 0);
		// protection boundary: block 7B free and 7C covered at setting 3, all covered at 8
		bp <= 5'h03;
		wren();
		op(8'h02, 32'h7BFFF0, 1, 0, 3);
		wren();
		op(8'h20, 32'h7C0000, 0, 0, 3);
		bp <= 5'h08;
		wren();
		op(8'h52, 32'h000000, 0, 0, 3);
		conclude();
	end
endmodule
